// File: src/thw_fifo.v
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module thw_fifo #(
  parameter WIDTH = 48,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  // Status
  output wire full_o
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  // Honest full and empty from the occupancy count
  assign full_o = (count_reg == DEPTH[AW:0]);
  assign in_ready_o = ~full_o;
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_reg[rd_ptr_reg];

  // Storage write, no reset needed on data
  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and count; DEPTH is a power of two so pointers wrap naturally
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// File: src/thw_hdr_wake.v
// Tunnel information header parser with type decode and emission wake field control
//
// Notes on behaviour
// - Header: address, port, length, group, type, two flags, wake pair, reserved, optional stamp.
// - Eight-bit type code names the packet kind that follows the header.
// - Codes 0, 7-13, 17-18, 19-127, 130-191, 196-254 decode as reserved.
// - Code 255 is accepted as unspecified class, no content assumed.
// - Code 195 decodes as its own emergency data class, apart from 192-194.
// - Timestamp flag one means four stamp bytes follow; zero means none consumed.
// - Wake pair is interpreted only for type codes 1 through 5.
// - Wake pair: first bit wake request, second bit new-alert wake flag.
// - Request one asks non-zero field; zero asks zero unless another source requests.
// - The two emitted wake bits are kept as one two-bit field.
// - Field 00 while off; each new-alert flag while on steps 1, 2, 3.
// - Requests of all sources are combined; any request keeps the field non-zero.
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "thw_regs.vh"
module thw_hdr_wake (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Header byte stream from the data sources
  input wire in_valid_i,
  output wire in_ready_o,
  input wire in_sop_i,
  input wire [7:0] in_data_i,
  input wire [1:0] in_src_i,
  // Decoded header stream to the scheduler
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [1:0] out_src_o,
  output wire [3:0] out_class_o,
  output wire [7:0] out_type_o,
  output wire out_rap_o,
  output wire out_ts_present_o,
  output wire [31:0] out_ts_o,
  // Emission wake field for the frame preamble
  output wire [1:0] emit_wake_o,
  output wire emitted_wake_bit_a_o,
  output wire emitted_wake_bit_b_o
);
  // Parser states, one-hot
  localparam S_IDLE = 4'b0001;
  localparam S_HDR = 4'b0010;
  localparam S_TS = 4'b0100;
  localparam S_PUSH = 4'b1000;

  // Parser state and captured header fields
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [3:0] idx_reg;
  reg [1:0] src_reg;
  reg [7:0] type_reg;
  reg [7:0] flags_reg;
  reg [31:0] ts_reg;
  // Control, wake, counter and bus state
  reg [1:0] ctrl_reg;
  reg [1:0] wake_reg;
  reg [1:0] wake_next;
  reg [`THW_NSRC-1:0] active_reg;
  reg [`THW_NSRC-1:0] active_next;
  reg [31:0] hdr_cnt_reg;
  reg [31:0] rsv_cnt_reg;
  reg [31:0] alert_cnt_reg;
  reg [31:0] rd_data_reg;
  reg ack_reg;
  // Internal strobes and buffer links
  wire take;
  wire hdr_done;
  wire wake_type;
  wire [3:0] cur_class;
  wire fifo_in_ready;
  wire fifo_full;
  wire [`THW_FIFO_WIDTH-1:0] fifo_din;
  wire [`THW_FIFO_WIDTH-1:0] fifo_dout;
  wire bus_req;
  wire bus_wr;

  // Type code to packet class
  function [3:0] classify;
    input [7:0] code;
    input t16_video;
    begin
      if (code >= `THW_TYPE_WAKE_LO && code <= `THW_TYPE_WAKE_HI) begin
        classify = `THW_CLS_SIG_MAIN;
      end else if (code == 8'h06 || code == 8'h0e || code == 8'h0f) begin
        classify = `THW_CLS_SIG_OTHER;
      end else if (code == `THW_TYPE_SHARED) begin
        // One class for the doubly listed code, picked by software
        classify = t16_video ? `THW_CLS_VIDEO : `THW_CLS_SESSION;
      end else if (code == 8'h80 || code == 8'h81) begin
        classify = `THW_CLS_AUDIO;
      end else if (code >= 8'hc0 && code <= 8'hc2) begin
        classify = `THW_CLS_APP;
      end else if (code == `THW_TYPE_EMERG) begin
        classify = `THW_CLS_EMERG;
      end else if (code == `THW_TYPE_UNSPEC) begin
        classify = `THW_CLS_UNSPEC;
      end else begin
        classify = `THW_CLS_RESERVED;
      end
    end
  endfunction

  // Type codes that carry a wake pair
  function is_wake_type;
    input [7:0] code;
    begin
      is_wake_type = (code >= `THW_TYPE_WAKE_LO) && (code <= `THW_TYPE_WAKE_HI);
    end
  endfunction

  // Next on-state; zero is never a successor while a request stands
  function [1:0] wake_advance;
    input [1:0] cur;
    begin
      if (cur == 2'h3) begin
        wake_advance = `THW_WAKE_FIRST;
      end else begin
        wake_advance = cur + 2'h1;
      end
    end
  endfunction

  // Input handshake; a disabled parser stalls the sources instead of losing bytes
  assign in_ready_o = ctrl_reg[`THW_CTRL_EN_BIT] & (state_reg != S_PUSH);
  assign take = in_valid_i & in_ready_o;
  assign cur_class = classify(type_reg, ctrl_reg[`THW_CTRL_T16_VIDEO_BIT]);
  assign wake_type = is_wake_type(type_reg);
  assign hdr_done = (state_reg == S_PUSH) & fifo_in_ready;

  // Parser next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        // Bytes outside a header are payload and are skipped
        if (take && in_sop_i) begin
          state_next = S_HDR;
        end
      end
      S_HDR: begin
        if (take && idx_reg == `THW_HDR_FLAG_IDX) begin
          // Stamp bytes only when the flag says so
          state_next = in_data_i[`THW_FLAG_TS_BIT] ? S_TS : S_PUSH;
        end
      end
      S_TS: begin
        if (take && idx_reg == `THW_TS_LAST_IDX) begin
          state_next = S_PUSH;
        end
      end
      S_PUSH: begin
        if (fifo_in_ready) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Parser registers; fixed part is twelve bytes in order
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      idx_reg <= 4'h0;
      src_reg <= 2'h0;
      type_reg <= 8'h00;
      flags_reg <= 8'h00;
      ts_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      if (state_reg == S_IDLE && take && in_sop_i) begin
        idx_reg <= 4'h1;
        src_reg <= in_src_i;
      end else if (state_reg == S_HDR && take) begin
        if (idx_reg == `THW_HDR_TYPE_IDX) begin
          type_reg <= in_data_i;
        end
        if (idx_reg == `THW_HDR_FLAG_IDX) begin
          // Reserved low bits are kept in flags_reg but never acted on
          flags_reg <= in_data_i;
          ts_reg <= 32'h0000_0000;
          idx_reg <= 4'h0;
        end else begin
          idx_reg <= idx_reg + 4'h1;
        end
      end else if (state_reg == S_TS && take) begin
        // Stamp arrives most significant byte first
        ts_reg <= {ts_reg[23:0], in_data_i};
        idx_reg <= idx_reg + 4'h1;
      end
    end
  end

  // Wake combining; pair bits are only looked at for wake types
  always @* begin
    active_next = active_reg;
    wake_next = wake_reg;
    if (hdr_done && wake_type) begin
      // Latest request of each source is held until it sends another
      active_next[src_reg] = flags_reg[`THW_FLAG_ACTIVE_BIT];
      // A dropped request clears the field only once every source is quiet
      if (active_next == {`THW_NSRC{1'b0}}) begin
        wake_next = `THW_WAKE_OFF;
      end else if (wake_reg == `THW_WAKE_OFF) begin
        // Turning on lands in the first state, alert or not
        wake_next = `THW_WAKE_FIRST;
      end else if (flags_reg[`THW_FLAG_ALERT_BIT]) begin
        // Step through 1, 2, 3 then back to 1
        wake_next = wake_advance(wake_reg);
      end
      // Any source still requesting keeps the field non-zero
    end
  end

  // Wake state registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      active_reg <= {`THW_NSRC{1'b0}};
      wake_reg <= `THW_WAKE_OFF;
    end else begin
      active_reg <= active_next;
      wake_reg <= wake_next;
    end
  end

  // Bit a is the upper half of the field, bit b the lower
  assign emit_wake_o = wake_reg;
  assign emitted_wake_bit_a_o = wake_reg[1];
  assign emitted_wake_bit_b_o = wake_reg[0];

  // Header, reserved and alert counters; they wrap and are cleared only by reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      hdr_cnt_reg <= 32'h0000_0000;
      rsv_cnt_reg <= 32'h0000_0000;
      alert_cnt_reg <= 32'h0000_0000;
    end else if (hdr_done) begin
      hdr_cnt_reg <= hdr_cnt_reg + 32'h0000_0001;
      if (cur_class == `THW_CLS_RESERVED) begin
        rsv_cnt_reg <= rsv_cnt_reg + 32'h0000_0001;
      end
      // Alert bits on other types carry no meaning and are not counted
      if (wake_type && flags_reg[`THW_FLAG_ALERT_BIT]) begin
        alert_cnt_reg <= alert_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Decoded header word; random-access marker passed through as sent
  assign fifo_din = {src_reg, cur_class, type_reg, flags_reg[`THW_FLAG_RAP_BIT],
                     flags_reg[`THW_FLAG_TS_BIT], ts_reg};

  // Buffer between parser and scheduler; a full buffer holds the parser in push
  thw_fifo #(
    .WIDTH(`THW_FIFO_WIDTH),
    .DEPTH(`THW_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(state_reg == S_PUSH),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_din),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(fifo_dout),
    .full_o(fifo_full)
  );

  // Fields of the buffered word
  assign out_src_o = fifo_dout[47:46];
  assign out_class_o = fifo_dout[45:42];
  assign out_type_o = fifo_dout[41:34];
  assign out_rap_o = fifo_dout[33];
  assign out_ts_present_o = fifo_dout[32];
  assign out_ts_o = fifo_dout[31:0];

  // Wishbone classic: one wait state, ack dropped after one cycle
  // Gating with ack keeps a strobe still held at the ack edge from being taken twice
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_wr = bus_req & wb_we_i;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_data_reg;

  // Control register write, low byte lane only
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `THW_CTRL_RESET;
    end else if (bus_wr && wb_sel_i[0] && wb_adr_i == `THW_CTRL_ADDR) begin
      ctrl_reg <= wb_dat_i[1:0];
    end
  end

  // Ack and read data; unmapped addresses ack with zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rd_data_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req;
      if (bus_req) begin
        case (wb_adr_i)
          `THW_CTRL_ADDR: begin
            rd_data_reg <= {30'h0000_0000, ctrl_reg};
          end
          `THW_STATUS_ADDR: begin
            // Busy covers a header being parsed or parked waiting for buffer room
            rd_data_reg <= {22'h00_0000, state_reg != S_IDLE, fifo_full, active_reg, 2'h0, wake_reg};
          end
          `THW_HDR_CNT_ADDR: begin
            rd_data_reg <= hdr_cnt_reg;
          end
          `THW_RSV_CNT_ADDR: begin
            rd_data_reg <= rsv_cnt_reg;
          end
          `THW_ALERT_CNT_ADDR: begin
            rd_data_reg <= alert_cnt_reg;
          end
          default: begin
            rd_data_reg <= 32'h0000_0000;
          end
        endcase
      end
    end
  end
endmodule

// File: src/thw_regs.vh
// Register offsets, field positions, reset values and header layout for the tunnel header block
`ifndef THW_REGS_VH
`define THW_REGS_VH

// Wishbone register byte offsets
`define THW_CTRL_ADDR 8'h00
`define THW_STATUS_ADDR 8'h04
`define THW_HDR_CNT_ADDR 8'h08
`define THW_RSV_CNT_ADDR 8'h0c
`define THW_ALERT_CNT_ADDR 8'h10

// Control register fields and reset value
`define THW_CTRL_EN_BIT 0
`define THW_CTRL_T16_VIDEO_BIT 1
`define THW_CTRL_RESET 2'h1

// Status register fields
`define THW_STAT_WAKE_LSB 0
`define THW_STAT_ACT_LSB 4
`define THW_STAT_FULL_BIT 8
`define THW_STAT_BUSY_BIT 9

// Header layout in bytes
`define THW_HDR_TYPE_IDX 4'ha
`define THW_HDR_FLAG_IDX 4'hb
`define THW_TS_LAST_IDX 4'h3
`define THW_FLAG_RAP_BIT 7
`define THW_FLAG_TS_BIT 6
`define THW_FLAG_ACTIVE_BIT 5
`define THW_FLAG_ALERT_BIT 4

// Type codes with a special meaning
`define THW_TYPE_WAKE_LO 8'h01
`define THW_TYPE_WAKE_HI 8'h05
`define THW_TYPE_SHARED 8'h10
`define THW_TYPE_EMERG 8'hc3
`define THW_TYPE_UNSPEC 8'hff

// Decoded packet classes
`define THW_CLS_RESERVED 4'h0
`define THW_CLS_SIG_MAIN 4'h1
`define THW_CLS_SIG_OTHER 4'h2
`define THW_CLS_SESSION 4'h3
`define THW_CLS_VIDEO 4'h4
`define THW_CLS_AUDIO 4'h5
`define THW_CLS_APP 4'h6
`define THW_CLS_EMERG 4'h7
`define THW_CLS_UNSPEC 4'h8

// Emission wake field values
`define THW_WAKE_OFF 2'h0
`define THW_WAKE_FIRST 2'h1

// Sizes
`define THW_NSRC 4
`define THW_FIFO_DEPTH 8
`define THW_FIFO_WIDTH 48

`endif

// File: verification/test_thw_hdr_wake.sv
// Self-checking bench for the tunnel header wake block
`timescale 1ns/1ps
module test_thw_hdr_wake;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  reg [7:0] wb_adr = 8'h00;
  reg [3:0] wb_sel = 4'h0;
  reg [31:0] wb_dat = 32'h0, r, mts = 32'h0;
  reg out_ready = 1'b0, go = 1'b0, gap = 1'b0, hold = 1'b0, v16 = 1'b0;
  reg [1:0] msrc = 2'h0, w = 2'h0;
  reg [7:0] mtype = 8'h00, mflags = 8'h00;
  reg [3:0] req = 4'h0;
  reg [23:0] e;
  integer seed = 32'he9d9, num_errors = 0, n_tests = 0, nhdr = 0, nrsv = 0, nalert = 0, i;
  reg [47:0] q[$];
  wire iv, ir, isop, ov, ra, rb, entry_point, tsp, busy, ack;
  wire [1:0] isrc, osrc, wk;
  wire [3:0] oc;
  wire [7:0] id, ot;
  wire [31:0] rd, ots;
  // Source, type, flags per step: alert example, then wrap and two sources
  localparam [407:0] WT = {72'h000100_000300_000430, 72'h000120_000420_000320, 72'h000430_000120_000100,
    72'h000400_010420_010430, 72'h010430_010430_020220, 48'h010100_020510};
  localparam [191:0] CT = {64'h00_06_07_0d_0e_0f_10_11, 64'h12_13_3f_40_7f_80_81_82, 64'hbf_c0_c1_c2_c3_c4_fe_ff};
  always #12.5 clk_i = ~clk_i;
  thw_src_model src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .gap_i(gap), .src_i(msrc), .type_i(mtype),
    .flags_i(mflags), .ts_i(mts), .ready_i(ir), .valid_o(iv), .sop_o(isop), .data_o(id), .src_o(isrc), .busy_o(busy));
  thw_hdr_wake DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(rd), .wb_ack_o(ack), .in_valid_i(iv),
    .in_ready_o(ir), .in_sop_i(isop), .in_data_i(id), .in_src_i(isrc), .out_valid_o(ov), .out_ready_i(out_ready),
    .out_src_o(osrc), .out_class_o(oc), .out_type_o(ot), .out_rap_o(entry_point), .out_ts_present_o(tsp),
    .out_ts_o(ots), .emit_wake_o(wk), .emitted_wake_bit_a_o(ra), .emitted_wake_bit_b_o(rb));
  task chk(input [47:0] got, input [47:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // One classic bus cycle, read data left in r
  task wb(input we, input [7:0] a, input [31:0] d, input [3:0] s);
    begin
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= s;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      r = rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  function [3:0] cls(input [7:0] t);
    begin
      if (t >= 8'h01 && t <= 8'h05) cls = 4'h1;
      else if (t == 8'h06 || t == 8'h0e || t == 8'h0f) cls = 4'h2;
      else if (t == 8'h10) cls = v16 ? 4'h4 : 4'h3;
      else if (t == 8'h80 || t == 8'h81) cls = 4'h5;
      else if (t >= 8'hc0 && t <= 8'hc2) cls = 4'h6;
      else if (t == 8'hc3) cls = 4'h7;
      else if (t == 8'hff) cls = 4'h8;
      else cls = 4'h0;
    end
  endfunction
  // Send one header, predict word and wake field
  task send(input [1:0] s, input [7:0] t, input [7:0] f);
    begin
      msrc <= s;
      mtype <= t;
      mflags <= f & 8'hf0;
      mts <= $random(seed);
      gap <= ~gap;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      while (busy) @(posedge clk_i);
      q.push_back({s, cls(t), t, f[7], f[6], f[6] ? mts : 32'h0});
      nhdr = nhdr + 1;
      if (cls(t) == 4'h0) nrsv = nrsv + 1;
      if (t >= 8'h01 && t <= 8'h05) begin
        req[s] = f[5];
        if (req == 4'h0) w = 2'h0;
        else if (w == 2'h0) w = 2'h1;
        else if (f[4]) w = (w == 2'h3) ? 2'h1 : w + 2'h1;
        if (f[4]) nalert = nalert + 1;
      end
      if (!hold) begin
        repeat (4) @(posedge clk_i);
        chk({wk, ra, rb}, {w, w});
      end
    end
  endtask
  // Scheduler side drains with random stalls
  always @(posedge clk_i) begin
    out_ready <= !hold && ($random(seed) & 3) != 0;
    if (ov === 1'b1 && out_ready) chk({osrc, oc, ot, entry_point, tsp, ots}, q.pop_front());
  end
  initial begin
    #500000;
    num_errors = num_errors + 1;
    test_done;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    chk(r, 32'h1);
    wb(1'b0, 8'h20, 32'h0, 4'hf);
    chk(r, 32'h0);
    wb(1'b1, 8'h00, 32'h3, 4'he);
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    chk(r, 32'h1);
    // Disabled parser must refuse bytes, then accept again once enabled
    wb(1'b1, 8'h00, 32'h0, 4'h1);
    chk(ir, 1'b0);
    wb(1'b1, 8'h00, 32'h1, 4'h1);
    chk(ir, 1'b1);
    for (i = 16; i >= 0; i = i - 1) begin
      e = WT[i * 24 +: 24];
      send(e[17:16], e[15:8], e[7:0]);
    end
    wb(1'b1, 8'h00, 32'h3, 4'hf);
    v16 = 1'b1;
    for (i = 0; i < 24; i = i + 1) begin
      r = $random(seed);
      send(r[1:0], CT[i * 8 +: 8], r[15:8]);
    end
    wb(1'b1, 8'h00, 32'h1, 4'hf);
    v16 = 1'b0;
    for (i = 0; i < 31; i = i + 1) begin
      r = $random(seed);
      send(r[1:0], i == 0 ? 8'h10 : r[15:8], r[23:16]);
    end
    // Buffer must be empty so that eight words fill it and the ninth parks
    while (q.size() != 0) @(posedge clk_i);
    hold = 1'b1;
    repeat (2) @(posedge clk_i);
    for (i = 0; i < 9; i = i + 1) send(2'h3, 8'h02, 8'h20);
    wb(1'b0, 8'h04, 32'h0, 4'hf);
    chk(r[8], 1'b1);
    chk(r[9], 1'b1);
    hold = 1'b0;
    while (q.size() != 0) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0, 4'hf);
    chk({r[8], r[7:4], r[1:0]}, {1'b0, req, w});
    wb(1'b0, 8'h08, 32'h0, 4'hf);
    chk(r, nhdr);
    wb(1'b0, 8'h0c, 32'h0, 4'hf);
    chk(r, nrsv);
    wb(1'b0, 8'h10, 32'h0, 4'hf);
    chk(r, nalert);
    test_done;
  end
endmodule

// File: verification/thw_hdr_wake_assertions.sv
// Port checker for the tunnel header wake block
`timescale 1ns/1ps
module thw_hdr_wake_assertions (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bus handshake
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // Decoded stream and wake field
  input wire out_valid_o,
  input wire out_ready_i,
  input wire [3:0] out_class_o,
  input wire [7:0] out_type_o,
  input wire [1:0] emit_wake_o,
  input wire emitted_wake_bit_a_o,
  input wire emitted_wake_bit_b_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Reserved code ranges, 17 and 18 included by choice
  wire rsv = out_type_o == 8'h00 || (out_type_o >= 8'h07 && out_type_o <= 8'h0d) ||
    (out_type_o >= 8'h11 && out_type_o <= 8'h7f) || (out_type_o >= 8'h82 && out_type_o <= 8'hbf) ||
    (out_type_o >= 8'hc4 && out_type_o <= 8'hfe);
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_wake_pair: assert property (emit_wake_o == {emitted_wake_bit_a_o, emitted_wake_bit_b_o})
    else $error("wake bits split from field");
  a_wake_enter: assert property ($past(emit_wake_o) == 2'h0 && emit_wake_o != 2'h0 |-> emit_wake_o == 2'h1)
    else $error("wake field left zero not to one");
  a_wake_step: assert property ($past(emit_wake_o) != 2'h0 && emit_wake_o != 2'h0 &&
    $changed(emit_wake_o) |-> emit_wake_o == ($past(emit_wake_o) == 2'h3 ? 2'h1 : $past(emit_wake_o) + 2'h1))
    else $error("wake field stepped wrongly");
  a_head_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_type_o))
    else $error("stalled head word changed");
  a_class_rsv: assert property (out_valid_o && rsv |-> out_class_o == 4'h0)
    else $error("reserved code not reserved class");
  a_class_emerg: assert property (out_valid_o && out_type_o == 8'hc3 |-> out_class_o == 4'h7)
    else $error("emergency code misclassed");
  a_class_unspec: assert property (out_valid_o && out_type_o == 8'hff |-> out_class_o == 4'h8)
    else $error("unspecified code misclassed");
  a_reset_idle: assert property (disable iff (1'b0) rst_i |=> emit_wake_o == 2'h0 && !out_valid_o)
    else $error("outputs not idle in reset");
endmodule

bind thw_hdr_wake thw_hdr_wake_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
  .out_class_o(out_class_o), .out_type_o(out_type_o), .emit_wake_o(emit_wake_o),
  .emitted_wake_bit_a_o(emitted_wake_bit_a_o), .emitted_wake_bit_b_o(emitted_wake_bit_b_o));

// File: verification/thw_src_model.sv
// Data source model sending tunnel information headers
`timescale 1ns/1ps
module thw_src_model (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Header request from the bench
  input wire go_i,
  input wire gap_i,
  input wire [1:0] src_i,
  input wire [7:0] type_i,
  input wire [7:0] flags_i,
  input wire [31:0] ts_i,
  // Byte stream toward the block
  input wire ready_i,
  output reg valid_o,
  output reg sop_o,
  output reg [7:0] data_o,
  output reg [1:0] src_o,
  output reg busy_o
);
  reg [4:0] idx_reg;
  wire [4:0] last = flags_i[6] ? 5'd15 : 5'd11;
  // Byte at a header position, stamp MSB first
  function [7:0] hb(input [4:0] i);
    begin
      if (i == 5'd10) hb = type_i;
      else if (i == 5'd11) hb = flags_i;
      else if (i > 5'd11) hb = ts_i[8 * (15 - i) +: 8];
      else hb = {3'h5, i};
    end
  endfunction
  // Idle line shows the inverse of the last byte, not a stale copy
  always @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      busy_o <= 1'b0;
      sop_o <= 1'b0;
      data_o <= 8'hff;
      src_o <= 2'h0;
      idx_reg <= 5'h0;
    end else if (go_i && !busy_o) begin
      busy_o <= 1'b1;
      valid_o <= 1'b1;
      sop_o <= 1'b1;
      idx_reg <= 5'h0;
      data_o <= hb(5'h0);
      src_o <= src_i;
    end else if (valid_o && ready_i) begin
      sop_o <= 1'b0;
      idx_reg <= idx_reg + 5'h1;
      if (idx_reg == last || gap_i) begin
        valid_o <= 1'b0;
        data_o <= ~data_o;
        busy_o <= idx_reg != last;
      end else data_o <= hb(idx_reg + 5'h1);
    end else if (busy_o) begin
      valid_o <= 1'b1;
      data_o <= hb(idx_reg);
    end
  end
endmodule
